// ===== hw/vcr_pkg.sv
package vcr_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CODE_LOW   = 8'h03;
  localparam logic [7:0] OFS_CONTROL    = 8'h04;
  localparam logic [7:0] OFS_MASK_FIRST = 8'h05;
  localparam logic [7:0] OFS_MASK_SEC   = 8'h06;
  localparam logic [7:0] OFS_STAT_FIRST = 8'h07;
  localparam logic [7:0] OFS_STAT_SEC   = 8'h08;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_CODE_LOW   = 8'h7D;
  localparam logic [7:0] RST_CONTROL    = 8'h04;
  localparam logic [7:0] RST_MASK_FIRST = 8'h7F;
  localparam logic [7:0] RST_MASK_SEC   = 8'hFF;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int CTL_MEASURE_START = 7;
  localparam int CTL_NV_COMMIT     = 6;
  localparam int CTL_PIN_FLOAT     = 5;
  localparam int CTL_AVG_HI        = 4;
  localparam int CTL_AVG_LO        = 3;
  localparam int CTL_CODE_MSB      = 0;

  // ----------------------------------------------------------------
  // first mask register fields
  // ----------------------------------------------------------------
  localparam int MSK_TEMP_DELTA   = 7;
  localparam int MSK_MEASURE_DONE = 1;
  localparam int MSK_BURN_DONE    = 0;
  localparam logic [7:0] MSK_FIRST_RW_BITS = 8'h7C;

  // ----------------------------------------------------------------
  // bias code and its output level
  // ----------------------------------------------------------------
  localparam int CODE_W = 9;
  localparam int LEVEL_W = 14;
  localparam logic [4:0] BIAS_STEP_MV = 5'h0A;

  // ----------------------------------------------------------------
  // serial port
  // ----------------------------------------------------------------
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h68;
  localparam logic [3:0] BITS_PER_BYTE    = 4'h8;

  typedef enum logic [3:0] {
    I2C_IDLE     = 4'b0000,
    I2C_ADDR     = 4'b0001,
    I2C_ADDR_ACK = 4'b0010,
    I2C_PTR      = 4'b0011,
    I2C_PTR_ACK  = 4'b0100,
    I2C_WDATA    = 4'b0101,
    I2C_WDAT_ACK = 4'b0110,
    I2C_RDATA    = 4'b0111,
    I2C_RDAT_ACK = 4'b1000
  } vcr_i2c_state_type;

  typedef enum logic [1:0] {
    MEAS_IDLE = 2'b00,
    MEAS_CONV = 2'b01,
    MEAS_WAIT = 2'b10,
    MEAS_DONE = 2'b11
  } vcr_meas_state_type;

  typedef enum logic {
    NV_IDLE = 1'b0,
    NV_BURN = 1'b1
  } vcr_nv_state_type;

endpackage : vcr_pkg

// ===== hw/vcr_i2c_slave.sv
`timescale 1ns/1ps
`default_nettype none
module vcr_i2c_slave import vcr_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  output logic            sdaOeN,
  output logic            regWrStb,
  output logic            regRdStb,
  output logic [7:0]      regAddr,
  output logic [7:0]      regWrData,
  input  wire logic [7:0] regRdData
);

  // ----------------------------------------------------------------
  // bit and frame detection
  // ----------------------------------------------------------------
  vcr_i2c_state_type state_q, state_d;
  logic       sclPrev_q, sdaPrev_q;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] shift_q, shift_d;
  logic [7:0] ptr_q, ptr_d;
  logic       rdMode_q, rdMode_d;
  logic       oeN_q, oeN_d;
  logic       wrStb_q, wrStb_d, rdStb_q, rdStb_d;
  logic [7:0] wrData_q, wrData_d;
  logic       sclRise, sclFall, startCond, stopCond, byteFull;

  assign sclRise   = sclIn & ~sclPrev_q;
  assign sclFall   = ~sclIn & sclPrev_q;
  assign startCond = sclIn & sclPrev_q & sdaPrev_q & ~sdaIn;
  assign stopCond  = sclIn & sclPrev_q & ~sdaPrev_q & sdaIn;
  assign byteFull  = (cnt_q == BITS_PER_BYTE);

  // ----------------------------------------------------------------
  // protocol engine
  // ----------------------------------------------------------------
  always_comb begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    shift_d  = shift_q;
    ptr_d    = ptr_q;
    rdMode_d = rdMode_q;
    oeN_d    = oeN_q;
    wrStb_d  = 1'b0;
    rdStb_d  = 1'b0;
    wrData_d = wrData_q;
    if (startCond) begin
      state_d = I2C_ADDR;
      cnt_d   = 4'h0;
      oeN_d   = 1'b1;
    end else if (stopCond) begin
      state_d = I2C_IDLE;
      oeN_d   = 1'b1;
    end else if (sclRise) begin
      unique case (state_q)
        I2C_ADDR, I2C_PTR, I2C_WDATA: begin
          shift_d = {shift_q[6:0], sdaIn};
          cnt_d   = cnt_q + 4'h1;
        end
        I2C_RDATA: cnt_d = cnt_q + 4'h1;
        // a not-acknowledge from the master ends the read burst
        I2C_RDAT_ACK: begin
          rdMode_d = ~sdaIn;
          ptr_d    = ptr_q + {7'h00, ~sdaIn};
        end
        default: ;
      endcase
    end else if (sclFall) begin
      unique case (state_q)
        I2C_ADDR: if (byteFull) begin
          cnt_d = 4'h0;
          if (shift_q[7:1] == DEV_ADDR) begin
            rdMode_d = shift_q[0];
            oeN_d    = 1'b0;
            state_d  = I2C_ADDR_ACK;
          end else begin
            state_d = I2C_IDLE;
          end
        end
        I2C_ADDR_ACK, I2C_RDAT_ACK: begin
          if (rdMode_q) begin
            shift_d = regRdData;
            rdStb_d = 1'b1;
            oeN_d   = regRdData[7];
            state_d = I2C_RDATA;
          end else begin
            oeN_d   = 1'b1;
            state_d = (state_q == I2C_ADDR_ACK) ? I2C_PTR : I2C_IDLE;
          end
        end
        I2C_PTR: if (byteFull) begin
          ptr_d   = shift_q;
          cnt_d   = 4'h0;
          oeN_d   = 1'b0;
          state_d = I2C_PTR_ACK;
        end
        I2C_WDATA: if (byteFull) begin
          wrData_d = shift_q;
          wrStb_d  = 1'b1;
          cnt_d    = 4'h0;
          oeN_d    = 1'b0;
          state_d  = I2C_WDAT_ACK;
        end
        I2C_PTR_ACK, I2C_WDAT_ACK: begin
          oeN_d   = 1'b1;
          if (state_q == I2C_WDAT_ACK) begin
            ptr_d = ptr_q + 8'h01;
          end
          state_d = I2C_WDATA;
        end
        I2C_RDATA: begin
          if (byteFull) begin
            cnt_d   = 4'h0;
            oeN_d   = 1'b1;
            state_d = I2C_RDAT_ACK;
          end else begin
            shift_d = {shift_q[6:0], 1'b0};
            oeN_d   = shift_q[6];
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q   <= I2C_IDLE;
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
      cnt_q     <= 4'h0;
      shift_q   <= 8'h00;
      ptr_q     <= 8'h00;
      rdMode_q  <= 1'b0;
      oeN_q     <= 1'b1;
      wrStb_q   <= 1'b0;
      rdStb_q   <= 1'b0;
      wrData_q  <= 8'h00;
    end else begin
      state_q   <= state_d;
      sclPrev_q <= sclIn;
      sdaPrev_q <= sdaIn;
      cnt_q     <= cnt_d;
      shift_q   <= shift_d;
      ptr_q     <= ptr_d;
      rdMode_q  <= rdMode_d;
      oeN_q     <= oeN_d;
      wrStb_q   <= wrStb_d;
      rdStb_q   <= rdStb_d;
      wrData_q  <= wrData_d;
    end
  end

  assign sdaOeN    = oeN_q;
  assign regWrStb  = wrStb_q;
  assign regRdStb  = rdStb_q;
  assign regWrData = wrData_q;
  assign regAddr   = ptr_q;

endmodule : vcr_i2c_slave
`default_nettype wire

// ===== hw/vcr_measure_avg.sv
`timescale 1ns/1ps
`default_nettype none
module vcr_measure_avg import vcr_pkg::*; #(
  parameter int SAMPLE_W = CODE_W
) (
  input  wire logic                sys_clk,
  input  wire logic                rst,
  input  wire logic                start,
  input  wire logic [1:0]          countSel,
  output logic                     adcStart,
  input  wire logic                adcDone,
  input  wire logic [SAMPLE_W-1:0] adcData,
  output logic                     done,
  output logic [SAMPLE_W-1:0]      result
);

  if (SAMPLE_W < 1 || SAMPLE_W > 16) begin : g_bad_width
    $error("sample width out of range");
  end

  // ----------------------------------------------------------------
  // conversion loop
  // ----------------------------------------------------------------
  // sum of up to eight samples needs three extra bits
  vcr_meas_state_type state_q, state_d;
  logic [SAMPLE_W+2:0] sum_q, sum_d;
  logic [3:0]          left_q, left_d;
  logic [1:0]          sel_q, sel_d;
  logic                adcStart_q, adcStart_d, done_q, done_d;
  logic [SAMPLE_W-1:0] result_q, result_d;
  logic [SAMPLE_W+2:0] avg;

  assign avg = sum_q >> sel_q;

  always_comb begin
    state_d    = state_q;
    sum_d      = sum_q;
    left_d     = left_q;
    sel_d      = sel_q;
    adcStart_d = 1'b0;
    done_d     = 1'b0;
    result_d   = result_q;
    unique case (state_q)
      MEAS_IDLE: if (start) begin
        sel_d   = countSel;
        left_d  = 4'h1 << countSel;
        sum_d   = '0;
        state_d = MEAS_CONV;
      end
      MEAS_CONV: begin
        adcStart_d = 1'b1;
        state_d    = MEAS_WAIT;
      end
      MEAS_WAIT: if (adcDone) begin
        sum_d   = sum_q + {3'h0, adcData};
        left_d  = left_q - 4'h1;
        state_d = (left_q == 4'h1) ? MEAS_DONE : MEAS_CONV;
      end
      MEAS_DONE: begin
        result_d = avg[SAMPLE_W-1:0];
        done_d   = 1'b1;
        state_d  = MEAS_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q    <= MEAS_IDLE;
      sum_q      <= '0;
      left_q     <= 4'h0;
      sel_q      <= 2'h0;
      adcStart_q <= 1'b0;
      done_q     <= 1'b0;
      result_q   <= '0;
    end else begin
      state_q    <= state_d;
      sum_q      <= sum_d;
      left_q     <= left_d;
      sel_q      <= sel_d;
      adcStart_q <= adcStart_d;
      done_q     <= done_d;
      result_q   <= result_d;
    end
  end

  assign adcStart = adcStart_q;
  assign done     = done_q;
  assign result   = result_q;

endmodule : vcr_measure_avg
`default_nettype wire

// ===== hw/vcr_ctrl_irq_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - nine-bit code split across low and control
// - output level is code times minus ten mV
// - writing one to measure start starts measurement
// - measurement end clears bit, loads result code
// - averaging field picks 1, 2, 4, 8 conversions
// - commit bit stores code into nonvolatile memory
// - commit end clears bit, enters standby
// - float bit releases bias pin, else driven
// - control resets 04h, bits 2,1 plain storage
// - enabled event pulls interrupt low, disabled not
// - temperature-change enable read-only zero
// - measure and commit done enables fixed one
// - first mask resets 7Fh, fault enables writable
// - second mask resets FFh, all writable
// - bias fault and negative regulator enables
// - bit zero enables temperature converter done
// - done flags set on measure and commit end
module vcr_ctrl_irq_regs import vcr_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
  input  wire logic                sys_clk,
  input  wire logic                rst,
  input  wire logic                sclIn,
  input  wire logic                sdaIn,
  output logic                     sdaOut,
  output logic                     sdaOeN,
  output logic                     adcStart,
  input  wire logic                adcDone,
  input  wire logic [CODE_W-1:0]   adcData,
  output logic                     nvWriteStart,
  output logic [CODE_W-1:0]        nvWriteCode,
  input  wire logic                nvDone,
  input  wire logic                nvLoadValid,
  input  wire logic [CODE_W-1:0]   nvLoadCode,
  output logic                     standbyReq,
  output logic [CODE_W-1:0]        biasCode,
  output logic signed [LEVEL_W-1:0] biasLevelMv,
  output logic                     biasPinFloat,
  input  wire logic [7:2]          faultFirst,
  input  wire logic [7:0]          faultSecond,
  output logic                     irqOutN
);

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  logic       regWrStb, regRdStb;
  logic [7:0] regAddr, regWrData;
  logic [7:0] regRdData;

  vcr_i2c_slave #(
    .DEV_ADDR (DEV_ADDR)
  ) u_i2c (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .sclIn     (sclIn),
    .sdaIn     (sdaIn),
    .sdaOeN    (sdaOeN),
    .regWrStb  (regWrStb),
    .regRdStb  (regRdStb),
    .regAddr   (regAddr),
    .regWrData (regWrData),
    .regRdData (regRdData)
  );

  // ----------------------------------------------------------------
  // measurement engine
  // ----------------------------------------------------------------
  logic              measStart, measDone;
  logic [CODE_W-1:0] measResult;
  logic [7:0]        ctrl_q, ctrl_d;

  vcr_measure_avg #(
    .SAMPLE_W (CODE_W)
  ) u_meas (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .start    (measStart),
    .countSel (ctrl_d[CTL_AVG_HI:CTL_AVG_LO]),
    .adcStart (adcStart),
    .adcDone  (adcDone),
    .adcData  (adcData),
    .done     (measDone),
    .result   (measResult)
  );

  // ----------------------------------------------------------------
  // code and control registers
  // ----------------------------------------------------------------
  logic [7:0]        codeLow_q, codeLow_d;
  logic              wrCtrl, nvStart, burnEnd;
  vcr_nv_state_type  nvState_q, nvState_d;
  logic              nvWriteStart_q, nvWriteStart_d;
  logic [CODE_W-1:0] nvWriteCode_q, nvWriteCode_d;
  logic              standbyReq_q, standbyReq_d;

  assign wrCtrl    = regWrStb && (regAddr == OFS_CONTROL);
  // a second start while busy is ignored; the bit already reads one
  assign measStart = wrCtrl && regWrData[CTL_MEASURE_START] && !ctrl_q[CTL_MEASURE_START];
  assign nvStart   = wrCtrl && regWrData[CTL_NV_COMMIT] && (nvState_q == NV_IDLE);
  assign burnEnd   = (nvState_q == NV_BURN) && nvDone;

  always_comb begin
    ctrl_d    = ctrl_q;
    codeLow_d = codeLow_q;
    if (nvLoadValid) begin
      {ctrl_d[CTL_CODE_MSB], codeLow_d} = nvLoadCode;
    end
    if (regWrStb && regAddr == OFS_CODE_LOW) begin
      codeLow_d = regWrData;
    end
    if (wrCtrl) begin
      // bits 5..0 plain storage; writing zero to 7 or 6 has no effect
      ctrl_d = regWrData;
      ctrl_d[CTL_MEASURE_START] = ctrl_q[CTL_MEASURE_START] | regWrData[CTL_MEASURE_START];
      ctrl_d[CTL_NV_COMMIT]     = ctrl_q[CTL_NV_COMMIT] | regWrData[CTL_NV_COMMIT];
    end
    // hardware completion wins over a host write in the same cycle
    if (measDone) begin
      ctrl_d[CTL_MEASURE_START]         = 1'b0;
      {ctrl_d[CTL_CODE_MSB], codeLow_d} = measResult;
    end
    if (burnEnd) begin
      ctrl_d[CTL_NV_COMMIT] = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // nonvolatile commit
  // ----------------------------------------------------------------
  always_comb begin
    nvState_d      = nvState_q;
    nvWriteStart_d = 1'b0;
    nvWriteCode_d  = nvWriteCode_q;
    standbyReq_d   = 1'b0;
    unique case (nvState_q)
      NV_IDLE: if (nvStart) begin
        // the code as it stands after this very write is committed
        nvWriteCode_d  = {ctrl_d[CTL_CODE_MSB], codeLow_d};
        nvWriteStart_d = 1'b1;
        nvState_d      = NV_BURN;
      end
      NV_BURN: if (nvDone) begin
        standbyReq_d = 1'b1;
        nvState_d    = NV_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // masks, flags and interrupt
  // ----------------------------------------------------------------
  logic [7:0] maskFirst_q, maskFirst_d;
  logic [7:0] maskSecond_q, maskSecond_d;
  logic       measFlag_q, measFlag_d;
  logic       burnFlag_q, burnFlag_d;
  logic [7:0] statFirst, statSecond;
  logic       irqOutN_q, irqOutN_d;
  logic       rdStatClr;

  assign statFirst  = {faultFirst, measFlag_q, burnFlag_q};
  assign statSecond = faultSecond;
  assign rdStatClr  = regRdStb && (regAddr == OFS_STAT_FIRST);

  always_comb begin
    maskFirst_d  = maskFirst_q;
    maskSecond_d = maskSecond_q;
    if (regWrStb && regAddr == OFS_MASK_FIRST) begin
      maskFirst_d = (maskFirst_q & ~MSK_FIRST_RW_BITS) | (regWrData & MSK_FIRST_RW_BITS);
    end
    maskFirst_d[MSK_TEMP_DELTA]   = 1'b0;
    maskFirst_d[MSK_MEASURE_DONE] = 1'b1;
    maskFirst_d[MSK_BURN_DONE]    = 1'b1;
    if (regWrStb && regAddr == OFS_MASK_SEC) begin
      maskSecond_d = regWrData;
    end
    // reading the first status register clears the done flags; set wins
    measFlag_d = (measFlag_q & ~rdStatClr) | measDone;
    burnFlag_d = (burnFlag_q & ~rdStatClr) | burnEnd;
    irqOutN_d  = ~|((statFirst & maskFirst_q) | (statSecond & maskSecond_q));
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    unique case (regAddr)
      OFS_CODE_LOW:   regRdData = codeLow_q;
      OFS_CONTROL:    regRdData = ctrl_q;
      OFS_MASK_FIRST: regRdData = maskFirst_q;
      OFS_MASK_SEC:   regRdData = maskSecond_q;
      OFS_STAT_FIRST: regRdData = statFirst;
      OFS_STAT_SEC:   regRdData = statSecond;
      default:        regRdData = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // output level
  // ----------------------------------------------------------------
  logic signed [LEVEL_W-1:0] level_q, level_d;
  logic        [LEVEL_W-1:0] levelMag;

  always_comb begin
    levelMag = LEVEL_W'({ctrl_q[CTL_CODE_MSB], codeLow_q}) * LEVEL_W'(BIAS_STEP_MV);
    level_d  = -$signed(levelMag);
  end

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_q         <= RST_CONTROL;
      codeLow_q      <= RST_CODE_LOW;
      nvState_q      <= NV_IDLE;
      nvWriteStart_q <= 1'b0;
      nvWriteCode_q  <= '0;
      standbyReq_q   <= 1'b0;
      maskFirst_q    <= RST_MASK_FIRST;
      maskSecond_q   <= RST_MASK_SEC;
      measFlag_q     <= 1'b0;
      burnFlag_q     <= 1'b0;
      irqOutN_q      <= 1'b1;
      level_q        <= -$signed(LEVEL_W'(RST_CODE_LOW) * LEVEL_W'(BIAS_STEP_MV));
    end else begin
      ctrl_q         <= ctrl_d;
      codeLow_q      <= codeLow_d;
      nvState_q      <= nvState_d;
      nvWriteStart_q <= nvWriteStart_d;
      nvWriteCode_q  <= nvWriteCode_d;
      standbyReq_q   <= standbyReq_d;
      maskFirst_q    <= maskFirst_d;
      maskSecond_q   <= maskSecond_d;
      measFlag_q     <= measFlag_d;
      burnFlag_q     <= burnFlag_d;
      irqOutN_q      <= irqOutN_d;
      level_q        <= level_d;
    end
  end

  // open-drain data line only ever pulls low
  logic sdaOut_q;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sdaOut_q <= 1'b0;
    end else begin
      sdaOut_q <= 1'b0;
    end
  end

  assign sdaOut       = sdaOut_q;
  assign nvWriteStart = nvWriteStart_q;
  assign nvWriteCode  = nvWriteCode_q;
  assign standbyReq   = standbyReq_q;
  assign biasCode     = {ctrl_q[CTL_CODE_MSB], codeLow_q};
  assign biasLevelMv  = level_q;
  assign biasPinFloat = ctrl_q[CTL_PIN_FLOAT];
  assign irqOutN      = irqOutN_q;

endmodule : vcr_ctrl_irq_regs
`default_nettype wire

// ===== bench/vcr_ctrl_irq_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module vcr_ctrl_irq_monitor import vcr_pkg::*; (
  input wire logic                      sys_clk,
  input wire logic                      rst,
  input wire logic                      adcStart,
  input wire logic                      adcDone,
  input wire logic                      nvWriteStart,
  input wire logic [CODE_W-1:0]         nvWriteCode,
  input wire logic                      nvDone,
  input wire logic                      standbyReq,
  input wire logic [CODE_W-1:0]         biasCode,
  input wire logic signed [LEVEL_W-1:0] biasLevelMv,
  input wire logic [7:2]                faultFirst,
  input wire logic [7:0]                faultSecond,
  input wire logic                      irqOutN
);
  // ----
  // cycles since last interrupt cause
  // ----
  logic [3:0] quiet_q;
  logic [3:0] quiet_d;
  always_comb begin
    quiet_d = (quiet_q == 4'hF) ? quiet_q : quiet_q + 4'h1;
    if (adcDone || nvDone || (|faultFirst[6:2]) || (|faultSecond)) quiet_d = 4'h0;
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) quiet_q <= 4'hF;
    else quiet_q <= quiet_d;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  chk_level_map: assert property (biasLevelMv == -10 * int'($past(biasCode)))
    else $error("bias level wrong");
  chk_commit_code: assert property (nvWriteStart |=> nvWriteCode == biasCode)
    else $error("commit code differs");
  chk_code_hold: assert property ($changed(nvWriteCode) |-> nvWriteStart || $past(nvWriteStart))
    else $error("commit code moved");
  chk_standby_due: assert property (nvWriteStart |-> ##[1:60] standbyReq)
    else $error("no standby");
  chk_standby_cause: assert property (standbyReq |-> $past(nvDone))
    else $error("stray standby");
  // partner answers four clocks after a start
  chk_conv_wait: assert property (adcStart |=> (!adcStart) [*4])
    else $error("early conversion");
  chk_burn_irq: assert property (nvDone |-> ##[1:4] !irqOutN)
    else $error("commit end silent");
  chk_irq_cause: assert property ($fell(irqOutN) |-> quiet_q < 4'h6)
    else $error("interrupt without cause");
endmodule : vcr_ctrl_irq_monitor
`default_nettype wire

// ===== bench/vcr_i2c_host.sv
`timescale 1ns/1ps
`default_nettype none
module vcr_i2c_host import vcr_pkg::*; #(
  parameter logic [6:0] ADDR = DEV_ADDR_DEFAULT
) (
  input  wire logic sys_clk,
  input  wire logic sdaIn,
  output var logic  sclOut,
  output var logic  sdaOeN
);
  // ----
  // bus phases, four clocks each
  // ----
  int nackCount = 0;
  initial begin
    sclOut = 1'b1;
    sdaOeN = 1'b1;
  end
  task automatic lvl(input logic c, input logic d);
    sclOut <= c;
    sdaOeN <= d;
    repeat (4) @(posedge sys_clk);
  endtask : lvl
  task automatic start();
    lvl(1'b0, 1'b1);
    lvl(1'b1, 1'b1);
    lvl(1'b1, 1'b0);
    lvl(1'b0, 1'b0);
  endtask : start
  // data only moves while the clock is low
  task automatic bits(input logic [8:0] d, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      lvl(1'b0, sdaOeN);
      lvl(1'b0, d[i]);
      lvl(1'b1, d[i]);
      r[i] = sdaIn;
    end
  endtask : bits
  task automatic tx(input logic [7:0] b);
    logic [8:0] r;
    bits({b, 1'b1}, r);
    if (r[0]) nackCount++;
  endtask : tx
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    start();
    tx({ADDR, 1'b0});
    tx(p);
    tx(d);
    lvl(1'b0, 1'b0);
    lvl(1'b1, 1'b0);
    lvl(1'b1, 1'b1);
  endtask : wr
  task automatic rd(input logic [7:0] p, output logic [7:0] d);
    logic [8:0] r;
    start();
    tx({ADDR, 1'b0});
    tx(p);
    start();
    tx({ADDR, 1'b1});
    bits(9'h1FF, r);
    d = r[8:1];
    lvl(1'b0, 1'b0);
    lvl(1'b1, 1'b0);
    lvl(1'b1, 1'b1);
  endtask : rd
endmodule : vcr_i2c_host
`default_nettype wire

// ===== bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top import vcr_pkg::*; ;
  // ----
  // stimulus and checks
  // ----
  logic                      sys_clk, rst, scl, adcStart, adcDone, nvWriteStart, nvDone, standbyReq;
  logic                      biasPinFloat, irqOutN, dutOeN, hostOeN;
  logic [CODE_W-1:0]         adcData, nvWriteCode, biasCode;
  logic signed [LEVEL_W-1:0] biasLevelMv;
  logic [7:2]                faultFirst;
  logic [7:0]                faultSecond;
  logic [2:0]                adcSr;
  logic [4:0]                nvSr;
  int                        failCount = 0, comparisons = 0, convCount = 0, standbyCount = 0;
  wire logic                 sda = hostOeN & dutOeN;
  vcr_ctrl_irq_regs dut (.sys_clk, .rst, .sclIn(scl), .sdaIn(sda), .sdaOut(), .sdaOeN(dutOeN), .adcStart,
    .adcDone, .adcData, .nvWriteStart, .nvWriteCode, .nvDone, .nvLoadValid(1'b0), .nvLoadCode(9'h000),
    .standbyReq, .biasCode, .biasLevelMv, .biasPinFloat, .faultFirst, .faultSecond, .irqOutN);
  vcr_i2c_host host (.sys_clk, .sdaIn(sda), .sclOut(scl), .sdaOeN(hostOeN));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    adcSr <= {adcSr[1:0], adcStart};
    adcDone <= adcSr[2];
    adcData <= 9'h120 + 9'(2 * convCount);
    if (adcSr[2]) convCount <= convCount + 1;
    nvSr <= {nvSr[3:0], nvWriteStart};
    nvDone <= nvSr[4];
    if (standbyReq) standbyCount <= standbyCount + 1;
  end
  task automatic finish_test();
    if (failCount == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      failCount++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    chk($sformatf("reg %h", a), {8'h00, d}, {8'h00, e});
  endtask : rchk
  task automatic settle();
    repeat (4) @(posedge sys_clk);
  endtask : settle
  task automatic waitIrq();
    for (int t = 0; t < 400 && irqOutN !== 1'b0; t++) @(posedge sys_clk);
    settle();
  endtask : waitIrq
  task automatic t_reset();
    rchk(OFS_CODE_LOW, 8'h7D);
    rchk(OFS_CONTROL, 8'h04);
    rchk(OFS_MASK_FIRST, 8'h7F);
    rchk(OFS_MASK_SEC, 8'hFF);
    chk("biasCode", 16'(biasCode), 16'h007D);
    chk("biasLevelMv", 16'(biasLevelMv), -16'h04E2);
    chk("irqOutN", 16'(irqOutN), 16'h0001);
  endtask : t_reset
  task automatic t_regs();
    host.wr(OFS_MASK_FIRST, 8'h00);
    rchk(OFS_MASK_FIRST, 8'h03);
    host.wr(OFS_MASK_FIRST, 8'hFF);
    rchk(OFS_MASK_FIRST, 8'h7F);
    host.wr(OFS_MASK_SEC, 8'h00);
    rchk(OFS_MASK_SEC, 8'h00);
    host.wr(OFS_CONTROL, 8'h26);
    rchk(OFS_CONTROL, 8'h26);
    chk("biasPinFloat", 16'(biasPinFloat), 16'h0001);
    chk("convCount", 16'(convCount), 16'h0000);
    host.wr(OFS_CODE_LOW, 8'hFF);
    host.wr(OFS_CONTROL, 8'h01);
    chk("biasCode", 16'(biasCode), 16'h01FF);
    chk("biasLevelMv", 16'(biasLevelMv), -16'h13F6);
    chk("biasPinFloat", 16'(biasPinFloat), 16'h0000);
  endtask : t_regs
  task automatic t_irq();
    logic [13:0] one;
    for (int k = 0; k < 13; k++) begin
      one = (k < 5) ? (14'h0100 << k) : (14'h0001 << (k - 5));
      if (k < 5) host.wr(OFS_MASK_FIRST, 8'h04 << k);
      else host.wr(OFS_MASK_SEC, 8'h01 << (k - 5));
      if (k == 5) host.wr(OFS_MASK_FIRST, 8'h00);
      {faultFirst, faultSecond} <= ~one;
      settle();
      chk("irqOutN", 16'(irqOutN), 16'h0001);
      {faultFirst, faultSecond} <= one;
      settle();
      chk("irqOutN", 16'(irqOutN), 16'h0000);
      {faultFirst, faultSecond} <= 14'h0000;
    end
  endtask : t_irq
  task automatic t_meas();
    for (int s = 0; s < 4; s++) begin
      host.wr(OFS_CONTROL, 8'h80 | 8'(s << 3));
      waitIrq();
      chk("convCount", 16'(convCount), 16'((2 << s) - 1));
      chk("biasCode", 16'(biasCode), 16'h0120 + 16'(3 * ((1 << s) - 1)));
      chk("irqOutN", 16'(irqOutN), 16'h0000);
      rchk(OFS_CONTROL, 8'(s << 3 | 1));
      rchk(OFS_STAT_FIRST, 8'h02);
      chk("irqOutN", 16'(irqOutN), 16'h0001);
    end
  endtask : t_meas
  task automatic t_commit();
    host.wr(OFS_CODE_LOW, 8'h5A);
    host.wr(OFS_CONTROL, 8'h40);
    waitIrq();
    chk("nvWriteCode", 16'(nvWriteCode), 16'h005A);
    chk("standbyCount", 16'(standbyCount), 16'h0001);
    rchk(OFS_CONTROL, 8'h00);
    rchk(OFS_STAT_FIRST, 8'h01);
  endtask : t_commit
  initial begin
    rst = 1'b1;
    {faultFirst, faultSecond} = 14'h0000;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    settle();
    t_reset();
    t_regs();
    t_irq();
    t_meas();
    t_commit();
    chk("nackCount", 16'(host.nackCount), 16'h0000);
    finish_test();
  end
  initial begin
    repeat (90000) @(posedge sys_clk);
    failCount++;
    finish_test();
  end
endmodule : tb_top
bind vcr_ctrl_irq_regs vcr_ctrl_irq_monitor u_mon (.sys_clk, .rst, .adcStart, .adcDone, .nvWriteStart,
  .nvWriteCode, .nvDone, .standbyReq, .biasCode, .biasLevelMv, .faultFirst, .faultSecond, .irqOutN);
`default_nettype wire
